// *** rtl/afe_code_if.sv ***
`timescale 1ns/1ps
interface afe_code_if;
  logic        sample_valid;
  logic [23:0] sample;
  logic        unipolar;
  logic        narrow;
  logic        dig_x2;
  logic        result_valid;
  logic [23:0] result;

  modport ctl (output sample_valid, output sample, output unipolar, output narrow, output dig_x2,
               input result_valid, input result);
  modport cod (input sample_valid, input sample, input unipolar, input narrow, input dig_x2,
               output result_valid, output result);
endinterface

// *** rtl/afe_coder.sv ***
`timescale 1ns/1ps
module afe_coder
  import afe_pkg::*;
(
  // clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst,
  // sample in, coded word out
  afe_code_if.cod     cif
);

  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } afe_cod_t;

  afe_cod_t    cod_r;
  afe_cod_t    cod_nxt;
  logic [23:0] gained;
  logic [23:0] coded;

  always_comb begin
    cod_nxt = cod_r;
    gained  = cif.sample;
    // gains 1 and 2 are applied here, with saturation
    if (cif.dig_x2) begin
      if (cif.sample[23] != cif.sample[22]) begin
        gained = cif.sample[23] ? 24'h800000 : 24'h7FFFFF;
      end else begin
        gained = {cif.sample[22:0], 1'b0};
      end
    end
    if (cif.unipolar) begin
      // straight binary: negative clamps to zero, full scale to all ones
      coded = gained[23] ? 24'h000000 : {gained[22:0], &gained[22:0]};
    end else begin
      coded = {~gained[23], gained[22:0]};
    end
    cod_nxt.valid = cif.sample_valid;
    if (cif.sample_valid) begin
      // narrow variant keeps the upper bits, right aligned
      cod_nxt.word = cif.narrow ? {8'h00, coded[23:8]} : coded;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cod_r <= '0;
    end else begin
      cod_r <= cod_nxt;
    end
  end

  assign cif.result_valid = cod_r.valid;
  assign cif.result       = cod_r.word;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  chk_bipolar_msb: assert property (cif.sample_valid && !cif.unipolar && !cif.dig_x2 && !cif.narrow
      |=> cif.result == {~$past(cif.sample[23]), $past(cif.sample[22:0])})
    else $error("bipolar code not offset binary");
  chk_unipolar_neg: assert property (cif.sample_valid && cif.unipolar && cif.sample[23]
      |=> cif.result == 24'h000000)
    else $error("unipolar negative input not zero");
  chk_narrow_top: assert property (cif.sample_valid && cif.narrow |=> cif.result[23:16] == 8'h00)
    else $error("narrow word has upper bits set");

endmodule // afe_coder

// *** rtl/afe_frontend.sv ***
`timescale 1ns/1ps
// Operation
// - buffer enable one routes selected input through the buffer amplifier.
// - buffer enable zero at gain 1 or 2 connects input straight to modulator.
// - gains above 2 force the buffer on regardless of the enable bit.
// - gain 4 and above enables the in-amp, fed from the buffer.
// - gains 1 and 2 are applied digitally, not by the in-amp.
// - three-bit gain field selects 1, 2, 4, 8, 16, 32, 64 or 128.
// - polarity bit picks unipolar or bipolar and sets the output coding.
// - unipolar results are straight binary, zero to all ones.
// - bipolar results are offset binary, midscale one followed by zeros.
// - result word is 16 bits narrow or 24 bits wide.
// - burnout bit switches both burnout sources together; zero turns them off.
// - excitation bits enable, steer to one pin and set 10uA/210uA/1mA.
// - bias field with boost decides which negative input is driven to mid supply.
// - boost one raises bias drive current for faster power-up.
// - reference select picks internal or external; internal stays off the pins.
// - 32 ones on serial input reset logic, filter, modulator and registers.
// - the same full reset happens at power-up.
// - reset pattern is data high for 32 consecutive serial clocks.
// - after reset the serial interface expects a communications write next.
module afe_frontend
  import afe_pkg::*;
#(
  parameter int RST_WAIT = RST_WAIT_CYC
)(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_din,
  // samples from the filter
  input  wire logic        i_sample_valid,
  input  wire logic [23:0] i_sample,
  // coded results
  output logic             o_result_valid,
  output logic      [23:0] o_result,
  // input path controls
  output logic             o_buffer_on,
  output logic             o_mod_direct,
  output logic             o_inamp_on,
  output logic      [2:0]  o_gain_select,
  output logic             o_digital_x2,
  // sensor currents and bias
  output logic             o_burnout_source,
  output logic             o_burnout_sink,
  output logic             o_excitation_pin_one,
  output logic             o_excitation_pin_two,
  output logic      [1:0]  o_excitation_mag,
  output logic             o_bias_input_negative_one,
  output logic             o_bias_input_negative_two,
  output logic             o_bias_boost,
  // reference
  output logic             o_ref_internal,
  output logic             o_ref_pins_connect,
  // reset outputs
  output logic             o_core_reset,
  output logic             o_iface_expect_comms,
  output logic             o_reset_busy
);

  typedef struct packed {
    logic [1:0]          sclk_sy;
    logic                sclk_d;
    logic [1:0]          din_sy;
    logic [5:0]          ones;
    logic [CFG_W-1:0]    cfg;
    logic [EXC_W-1:0]    exc;
    afe_state_t          st;
    logic [WAIT_W-1:0]   wait_cnt;
    logic                core_rst;
    logic [31:0]         rdata;
    logic [23:0]         last_result;
  } afe_fe_t;

  localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(RST_WAIT);

  afe_fe_t     fe_r;
  afe_fe_t     fe_nxt;
  afe_code_if  cif ();

  logic        sclk_rise;
  logic        serial_reset;
  logic [2:0]  gain_code;
  logic        gain_high;
  logic        buf_on;

  assign gain_code    = fe_r.cfg[CFG_GAIN_MSB:CFG_GAIN_LSB];
  assign gain_high    = gain_code >= GAIN_CODE_X4;
  assign buf_on       = fe_r.cfg[CFG_BUF_EN] | gain_high;
  // only the second synchroniser flop is looked at
  assign sclk_rise    = fe_r.sclk_sy[1] & ~fe_r.sclk_d;
  assign serial_reset = sclk_rise && fe_r.din_sy[1] && fe_r.ones == ONES_RESET - 6'h01;

  always_comb begin
    fe_nxt          = fe_r;
    fe_nxt.core_rst = 1'b0;
    fe_nxt.sclk_sy  = {fe_r.sclk_sy[0], i_sclk};
    fe_nxt.sclk_d   = fe_r.sclk_sy[1];
    fe_nxt.din_sy   = {fe_r.din_sy[0], i_din};
    fe_nxt.rdata    = 32'h00000000;

    // consecutive ones on the serial input, saturating so a held line fires once
    if (sclk_rise) begin
      if (!fe_r.din_sy[1]) begin
        fe_nxt.ones = 6'h00;
      end else if (fe_r.ones != ONES_RESET) begin
        fe_nxt.ones = fe_r.ones + 6'h01;
      end
    end

    if (cif.result_valid) begin
      fe_nxt.last_result = cif.result;
    end

    if (i_wr) begin
      case (i_addr)
        ADDR_CFG: begin
          fe_nxt.cfg = i_wdata[CFG_W-1:0];
        end
        ADDR_EXC: begin
          fe_nxt.exc = i_wdata[EXC_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        ADDR_CFG: begin
          fe_nxt.rdata = {21'h000000, fe_r.cfg};
        end
        ADDR_EXC: begin
          fe_nxt.rdata = {29'h00000000, fe_r.exc};
        end
        ADDR_STATUS: begin
          fe_nxt.rdata[ST_BUSY]                 = fe_r.st == AFE_HOLD;
          fe_nxt.rdata[ST_BUF_ON]               = buf_on;
          fe_nxt.rdata[ST_INAMP_ON]             = gain_high;
          fe_nxt.rdata[ST_DIRECT]               = ~buf_on;
          fe_nxt.rdata[ST_ONES_MSB:ST_ONES_LSB] = fe_r.ones;
        end
        ADDR_RESULT: begin
          fe_nxt.rdata = {8'h00, fe_r.last_result};
        end
        default: begin
          fe_nxt.rdata = 32'h00000000;
        end
      endcase
    end

    // hold-off timer after any reset, shown as busy
    case (fe_r.st)
      AFE_RUN: begin
      end
      AFE_HOLD: begin
        if (fe_r.wait_cnt <= WAIT_W'(1)) begin
          fe_nxt.st       = AFE_RUN;
          fe_nxt.wait_cnt = '0;
        end else begin
          fe_nxt.wait_cnt = fe_r.wait_cnt - WAIT_W'(1);
        end
      end
      default: begin
        fe_nxt.st = AFE_RUN;
      end
    endcase

    // the ones pattern outranks a register write in the same cycle
    if (serial_reset) begin
      fe_nxt.cfg         = CFG_RST;
      fe_nxt.exc         = EXC_RST;
      fe_nxt.last_result = 24'h000000;
      fe_nxt.core_rst    = 1'b1;
      fe_nxt.st          = AFE_HOLD;
      fe_nxt.wait_cnt    = WAIT_LOAD;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fe_r          <= '0;
      fe_r.cfg      <= CFG_RST;
      fe_r.exc      <= EXC_RST;
      fe_r.st       <= AFE_HOLD;
      fe_r.wait_cnt <= WAIT_LOAD;
      fe_r.core_rst <= 1'b1;
      // serial clock idles high; matching it here keeps a false edge out after reset
      fe_r.sclk_sy  <= 2'h3;
      fe_r.sclk_d   <= 1'b1;
    end else begin
      fe_r <= fe_nxt;
    end
  end

  // result coding
  assign cif.sample_valid = i_sample_valid;
  assign cif.sample       = i_sample;
  assign cif.unipolar     = fe_r.cfg[CFG_UNIPOLAR];
  assign cif.narrow       = ~fe_r.cfg[CFG_WIDE];
  assign cif.dig_x2       = gain_code == GAIN_CODE_X2;

  afe_coder u_coder (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .cif       (cif)
  );

  assign o_rdata                   = fe_r.rdata;
  assign o_result_valid            = cif.result_valid;
  assign o_result                  = cif.result;
  assign o_buffer_on               = buf_on;
  assign o_mod_direct              = ~buf_on;
  assign o_inamp_on                = gain_high;
  assign o_gain_select             = gain_code;
  assign o_digital_x2              = cif.dig_x2;
  assign o_burnout_source          = fe_r.cfg[CFG_BURNOUT];
  assign o_burnout_sink            = fe_r.cfg[CFG_BURNOUT];
  assign o_excitation_mag          = fe_r.exc[EXC_MAG_MSB:EXC_MAG_LSB];
  assign o_excitation_pin_one      = o_excitation_mag != EXC_MAG_OFF && !fe_r.exc[EXC_DIR];
  assign o_excitation_pin_two      = o_excitation_mag != EXC_MAG_OFF && fe_r.exc[EXC_DIR];
  assign o_bias_input_negative_one = fe_r.cfg[CFG_BIAS_HIGH:CFG_BIAS_LOW] == BIAS_IN1;
  assign o_bias_input_negative_two = fe_r.cfg[CFG_BIAS_HIGH:CFG_BIAS_LOW] == BIAS_IN2;
  // boost only matters while the generator drives a terminal
  assign o_bias_boost              = fe_r.cfg[CFG_BOOST]
                                     & (o_bias_input_negative_one | o_bias_input_negative_two);
  assign o_ref_internal            = fe_r.cfg[CFG_REF_INT];
  assign o_ref_pins_connect        = ~fe_r.cfg[CFG_REF_INT];
  assign o_core_reset              = fe_r.core_rst;
  assign o_iface_expect_comms      = fe_r.core_rst;
  assign o_reset_busy              = fe_r.st == AFE_HOLD;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  chk_buffer_forced: assert property (gain_code >= GAIN_CODE_X4 |-> o_buffer_on && !o_mod_direct)
    else $error("buffer not forced on at high gain");
  chk_buffer_bypass: assert property (!fe_r.cfg[CFG_BUF_EN] && gain_code < GAIN_CODE_X4
      |-> o_mod_direct && !o_buffer_on)
    else $error("unbuffered path not taken");
  chk_inamp_gain: assert property (o_inamp_on == (gain_code >= GAIN_CODE_X4) && !(o_inamp_on && o_digital_x2))
    else $error("in-amp enable does not follow gain");
  chk_burnout_pair: assert property (o_burnout_source == o_burnout_sink)
    else $error("burnout sources differ");
  chk_exc_one_pin: assert property (!(o_excitation_pin_one && o_excitation_pin_two))
    else $error("excitation on both pins");
  chk_ref_pins: assert property (o_ref_internal |-> !o_ref_pins_connect)
    else $error("internal reference on pins");
  chk_ones_reset: assert property (serial_reset |=> o_core_reset && o_iface_expect_comms
      && fe_r.cfg == CFG_RST && fe_r.exc == EXC_RST)
    else $error("ones pattern did not reset");
  chk_ones_count: assert property (sclk_rise && !fe_r.din_sy[1] |=> fe_r.ones == 6'h00 && !o_core_reset)
    else $error("zero bit did not clear ones count");
  chk_reset_busy: assert property (o_core_reset |-> o_reset_busy ##1 o_reset_busy)
    else $error("no hold-off after reset");
  chk_read_unmapped: assert property (i_rd && i_addr > ADDR_RESULT |=> o_rdata == 32'h00000000)
    else $error("unmapped read not zero");

  // register port, result pulse, excitation, bias boost, ones count and hold-off
  chk_cfg_write: assert property (i_wr && i_addr == ADDR_CFG && !serial_reset
      |=> fe_r.cfg == $past(i_wdata[CFG_W-1:0]))
    else $error("configuration write lost");
  chk_exc_write: assert property (i_wr && i_addr == ADDR_EXC && !serial_reset
      |=> fe_r.exc == $past(i_wdata[EXC_W-1:0]))
    else $error("excitation write lost");
  chk_cfg_readback: assert property (i_rd && i_addr == ADDR_CFG |=> o_rdata == {21'h000000, $past(fe_r.cfg)})
    else $error("configuration readback wrong");
  chk_status_busy: assert property (i_rd && i_addr == ADDR_STATUS
      |=> o_rdata[ST_BUSY] == $past(o_reset_busy))
    else $error("status busy bit wrong");
  chk_read_idle: assert property (!i_rd |=> o_rdata == 32'h00000000)
    else $error("read data not cleared");
  chk_result_pulse: assert property (i_sample_valid |=> o_result_valid)
    else $error("result not produced");
  chk_result_once: assert property (!i_sample_valid |=> !o_result_valid)
    else $error("result pulse without sample");
  chk_exc_off: assert property (o_excitation_mag == EXC_MAG_OFF
      |-> !o_excitation_pin_one && !o_excitation_pin_two)
    else $error("excitation pin on while off");
  chk_boost_idle: assert property (o_bias_boost |-> o_bias_input_negative_one || o_bias_input_negative_two)
    else $error("boost without bias drive");
  chk_holdoff_load: assert property (o_core_reset |-> o_reset_busy && fe_r.wait_cnt == WAIT_LOAD)
    else $error("hold-off not loaded");
  chk_busy_drop: assert property (o_reset_busy && fe_r.wait_cnt == WAIT_W'(1) && !serial_reset
      |=> !o_reset_busy)
    else $error("hold-off does not end");
  chk_ones_sat: assert property (fe_r.ones <= ONES_RESET)
    else $error("ones count past pattern length");
  chk_core_pulse: assert property (o_core_reset |=> !o_core_reset)
    else $error("core reset pulse stretched");

  cov_serial_reset: cover property (serial_reset);
  cov_forced_buffer: cover property (!fe_r.cfg[CFG_BUF_EN] && gain_high);
  cov_unipolar_result: cover property (o_result_valid && fe_r.cfg[CFG_UNIPOLAR]);
  cov_busy_ends: cover property (o_reset_busy ##1 !o_reset_busy);
  cov_narrow_result: cover property (o_result_valid && !fe_r.cfg[CFG_WIDE]);

endmodule // afe_frontend

// *** rtl/afe_pkg.sv ***
package afe_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0]  ADDR_CFG      = 8'h00;
  localparam logic [7:0]  ADDR_EXC      = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_RESULT   = 8'h0C;

  // configuration register fields
  localparam int          CFG_W         = 11;
  localparam int          CFG_BUF_EN    = 0;
  localparam int          CFG_GAIN_LSB  = 1;
  localparam int          CFG_GAIN_MSB  = 3;
  localparam int          CFG_UNIPOLAR  = 4;
  localparam int          CFG_BURNOUT   = 5;
  localparam int          CFG_BIAS_LOW  = 6;
  localparam int          CFG_BIAS_HIGH = 7;
  localparam int          CFG_BOOST     = 8;
  localparam int          CFG_REF_INT   = 9;
  localparam int          CFG_WIDE      = 10;
  localparam logic [10:0] CFG_RST       = 11'h401;

  // excitation register fields
  localparam int          EXC_W         = 3;
  localparam int          EXC_DIR       = 0;
  localparam int          EXC_MAG_LSB   = 1;
  localparam int          EXC_MAG_MSB   = 2;
  localparam logic [2:0]  EXC_RST       = 3'h0;
  localparam logic [1:0]  EXC_MAG_OFF   = 2'h0;
  localparam logic [1:0]  EXC_MAG_10UA  = 2'h1;
  localparam logic [1:0]  EXC_MAG_210UA = 2'h2;
  localparam logic [1:0]  EXC_MAG_1MA   = 2'h3;

  // bias control codes
  localparam logic [1:0]  BIAS_OFF      = 2'h0;
  localparam logic [1:0]  BIAS_IN1      = 2'h1;
  localparam logic [1:0]  BIAS_IN2      = 2'h2;

  // status register fields
  localparam int          ST_BUSY       = 0;
  localparam int          ST_BUF_ON     = 1;
  localparam int          ST_INAMP_ON   = 2;
  localparam int          ST_DIRECT     = 3;
  localparam int          ST_ONES_LSB   = 8;
  localparam int          ST_ONES_MSB   = 13;

  // gain codes: code k selects gain 2**k
  localparam logic [2:0]  GAIN_CODE_X2  = 3'h1;
  localparam logic [2:0]  GAIN_CODE_X4  = 3'h2;

  // result widths
  localparam int          RES_W_WIDE    = 24;
  localparam int          RES_W_NARROW  = 16;

  // serial reset pattern
  localparam logic [5:0]  ONES_RESET    = 6'h20;

  // timing
  localparam int          CLK_MHZ       = 40;
  localparam int          RST_WAIT_US   = 500;
  localparam int          RST_WAIT_CYC  = RST_WAIT_US * CLK_MHZ;
  localparam int          WAIT_W        = 15;

  typedef enum logic [1:0] {
    AFE_RUN  = 2'b01,
    AFE_HOLD = 2'b10
  } afe_state_t;

endpackage

// *** tb/adc_frontend_config_and_coding_bench.sv ***
`timescale 1ns/1ps
module adc_frontend_config_and_coding_bench;
  import afe_pkg::*;
  localparam int RW = 20;
  logic        i_sys_clk, i_rst, i_wr, i_rd, i_sclk, i_din, i_sample_valid;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [23:0] i_sample, o_result, last_res;
  logic        o_result_valid, o_buffer_on, o_mod_direct, o_inamp_on, o_digital_x2;
  logic [2:0]  o_gain_select;
  logic        o_burnout_source, o_burnout_sink, o_excitation_pin_one, o_excitation_pin_two;
  logic [1:0]  o_excitation_mag;
  logic        o_bias_input_negative_one, o_bias_input_negative_two, o_bias_boost;
  logic        o_ref_internal, o_ref_pins_connect, o_core_reset, o_iface_expect_comms, o_reset_busy;
  logic [10:0] cfg;
  logic [13:0] e;
  logic [13:0] got_dec;
  logic [23:0] corners [4] = '{24'h000000, 24'h7FFFFF, 24'h800000, 24'h400000};
  int          miscompares = 0;
  int          comparisons = 0;
  int          n_core = 0;
  int          n_comms = 0;
  integer      seed = 32'h6A27085C;

  afe_frontend #(.RST_WAIT(RW)) i_dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_sclk, .i_din, .i_sample_valid, .i_sample, .o_result_valid, .o_result, .o_buffer_on, .o_mod_direct,
    .o_inamp_on, .o_gain_select, .o_digital_x2, .o_burnout_source, .o_burnout_sink, .o_excitation_pin_one,
    .o_excitation_pin_two, .o_excitation_mag, .o_bias_input_negative_one, .o_bias_input_negative_two,
    .o_bias_boost, .o_ref_internal, .o_ref_pins_connect, .o_core_reset, .o_iface_expect_comms, .o_reset_busy);

  afe_host_model i_host (.i_sys_clk, .o_sclk(i_sclk), .o_din(i_din));

  assign got_dec = {o_buffer_on, o_mod_direct, o_inamp_on, o_gain_select, o_digital_x2, o_burnout_source,
                    o_burnout_sink, o_bias_input_negative_one, o_bias_input_negative_two, o_bias_boost,
                    o_ref_internal, o_ref_pins_connect};

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // counts pulse cycles outside reset, so a stretched pulse shows up too
  always @(posedge i_sys_clk) begin
    if (!i_rst) begin
      if (o_core_reset === 1'b1) n_core++;
      if (o_iface_expect_comms === 1'b1) n_comms++;
    end
  end

  function automatic logic [13:0] exp_dec(input logic [10:0] c);
    logic [2:0] g;
    logic       b;
    logic [1:0] v;
    g = c[CFG_GAIN_MSB:CFG_GAIN_LSB];
    v = c[CFG_BIAS_HIGH:CFG_BIAS_LOW];
    b = c[CFG_BUF_EN] | (g >= GAIN_CODE_X4);
    exp_dec = {b, ~b, g >= GAIN_CODE_X4, g, g == GAIN_CODE_X2, c[CFG_BURNOUT], c[CFG_BURNOUT], v == BIAS_IN1,
               v == BIAS_IN2, c[CFG_BOOST] & (v == BIAS_IN1 || v == BIAS_IN2), c[CFG_REF_INT], ~c[CFG_REF_INT]};
  endfunction

  function automatic logic [23:0] exp_code(input logic [23:0] s, input logic [10:0] c);
    logic [23:0] x, y;
    x = s;
    if (c[CFG_GAIN_MSB:CFG_GAIN_LSB] == GAIN_CODE_X2)
      x = (s[23] != s[22]) ? (s[23] ? 24'h800000 : 24'h7FFFFF) : {s[22:0], 1'b0};
    if (c[CFG_UNIPOLAR]) y = x[23] ? 24'h000000 : {x[22:0], &x[22:0]};
    else y = {~x[23], x[22:0]};
    exp_code = c[CFG_WIDE] ? y : {8'h00, y[23:8]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 chk(nm, exp, o_rdata);
  endtask

  task automatic smp(input logic [23:0] s, input logic [10:0] c);
    @(posedge i_sys_clk);
    i_sample       <= s;
    i_sample_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_sample_valid <= 1'b0;
    last_res = exp_code(s, c);
    #1 chk("result_valid", 1, o_result_valid);
    chk("result", {8'h00, last_res}, {8'h00, o_result});
    @(posedge i_sys_clk);
    #1 chk("result_valid_low", 0, o_result_valid);
  endtask

  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge i_sys_clk);
    miscompares++;
    results();
  end

  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_sample_valid = 1'b0;
    i_sample = 24'h0;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk("busy_after_reset", 1, o_reset_busy);
    // host keeps off the registers until the hold-off has run out
    repeat (RW + 4) @(posedge i_sys_clk);
    #1 chk("busy_done", 0, o_reset_busy);
    chk("core_pulses", 1, n_core);
    chk("comms_pulses", 1, n_comms);
    rd(ADDR_CFG, {21'h0, CFG_RST}, "cfg_default");
    rd(ADDR_EXC, {29'h0, EXC_RST}, "exc_default");
    rd(8'h10, 32'h0, "unmapped");
    // every gain code with buffer enable clear first, then random settings
    for (int i = 0; i < 40; i++) begin
      cfg = (i < 8) ? {7'h00, i[2:0], 1'b0} : 11'($random(seed));
      wr(ADDR_CFG, {21'h0, cfg});
      #1 chk("decode", exp_dec(cfg), got_dec);
      if (i % 4 == 0) rd(ADDR_CFG, {21'h0, cfg}, "cfg_readback");
      smp(24'($random(seed)), cfg);
    end
    // full-scale, zero and saturating samples in every coding mode
    for (int j = 0; j < 8; j++) begin
      cfg = {j[0], 5'h00, j[1], (j[2] ? GAIN_CODE_X2 : 3'h0), 1'b1};
      wr(ADDR_CFG, {21'h0, cfg});
      foreach (corners[k]) smp(corners[k], cfg);
    end
    e = exp_dec(cfg);
    rd(ADDR_STATUS, {28'h0, e[12], e[11], e[13], 1'b0}, "status");
    wr(ADDR_RESULT, 32'h00FFFFFF);
    rd(ADDR_RESULT, {8'h00, last_res}, "result_read_only");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_EXC, k);
      #1 chk("excitation", {k[2:1] != 0 && !k[0], k[2:1] != 0 && k[0], k[2:1]},
             {o_excitation_pin_one, o_excitation_pin_two, o_excitation_mag});
    end
    wr(ADDR_CFG, 32'h000000F4);
    i_host.frame(31, 1'b1);
    repeat (10) @(posedge i_sys_clk);
    #1 chk("no_reset_31", 1, n_core);
    rd(ADDR_CFG, 32'h000000F4, "cfg_kept");
    i_host.frame(32, 1'b0);
    repeat (10) @(posedge i_sys_clk);
    #1 chk("serial_reset", 2, n_core);
    chk("serial_comms", 2, n_comms);
    chk("serial_busy", 1, o_reset_busy);
    repeat (RW) @(posedge i_sys_clk);
    rd(ADDR_CFG, {21'h0, CFG_RST}, "cfg_after_serial");
    rd(ADDR_EXC, {29'h0, EXC_RST}, "exc_after_serial");
    chk("decode_after_serial", exp_dec(CFG_RST), got_dec);
    results();
  end
endmodule // adc_frontend_config_and_coding_bench

// *** tb/afe_host_model.sv ***
`timescale 1ns/1ps
module afe_host_model (
  // system clock used for pacing
  input  wire logic i_sys_clk,
  // serial pins towards the device
  output logic      o_sclk,
  output logic      o_din
);
  // serial clock idles high and stands still between frames
  initial begin
    o_sclk = 1'b1;
    o_din  = 1'b0;
  end

  // low half lasts three system clocks, high half four or more, so the synchroniser sees each
  task automatic bit_out(input logic b);
    @(posedge i_sys_clk);
    o_sclk <= 1'b0;
    o_din  <= b;
    repeat (3) @(posedge i_sys_clk);
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
  endtask

  task automatic frame(input int ones, input logic tail);
    for (int i = 0; i < ones; i++) bit_out(1'b1);
    if (tail) bit_out(1'b0);
    @(posedge i_sys_clk);
    // released data line shows the inverse of the last bit
    o_din <= ~o_din;
  endtask
endmodule // afe_host_model
